/* design/nvua_core.sv */
// Command decode, thermal lockout and nonvolatile access sequencing
`timescale 1ns/100ps
`default_nettype none
module nvua_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Command from serial engine
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_write,
	input wire logic cmd_has_data,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_page,
	input wire logic [4:0] str_idx,
	// Environment
	input wire logic [7:0] die_temp_c,
	input wire logic log_enable,
	input wire logic mem_differs,
	input wire logic mem_busy,
	// Read answer
	output logic [15:0] rd_data,
	output logic [7:0] rd_len,
	output logic rd_valid,
	// Memory actions
	output logic nv_store,
	output logic nv_load,
	output logic nv_log_write,
	output logic pwm_force_off,
	output logic faults_clear,
	output logic pins_sample,
	output logic soft_start,
	// Status
	output logic cml_fault,
	output logic hot_flag,
	output logic lockout,
	output logic log_pending
);
	import nvua_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		nvua_state_t st;
		logic lock;
		logic pend;
		logic [15:0] scr_p0;
		logic [15:0] scr_p1;
		logic [15:0] scr_g;
		logic [15:0] rdat;
		logic [7:0] rlen;
		logic rval;
		logic store;
		logic load;
		logic logw;
		logic pwm_off;
		logic fclr;
		logic pins;
		logic start;
		logic comm_memory_logic_fault;
		logic hot;
	} nvua_st_t;

	nvua_st_t s_r;
	nvua_st_t s_nxt;
	logic [1:0] rsync_r;
	logic rst_int_n;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rsync_r <= 2'b00;
		else
			rsync_r <= {rsync_r[0], 1'b1};
	end
	assign rst_int_n = rsync_r[1];

	function automatic logic [7:0] str_char(input logic [7:0] code, input logic [4:0] idx);
		logic [7:0] c;
		c = 8'h00;
		if (idx == 5'd0)
			c = {4'h0, STR_LEN};
		else if (idx <= 5'(STR_LEN))
		begin
			case (code)
				CMD_MAKER_STR: c = MAKER_CH[idx[1:0] - 2'd1];
				CMD_MODEL_STR: c = MODEL_CH[idx[1:0] - 2'd1];
				default: c = SERIAL_CH[idx[1:0] - 2'd1];
			endcase
		end
		return c;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic cool;
		logic act;
		cool = 1'b0;
		act = 1'b0;
		s_nxt = s_r;
		s_nxt.store = 1'b0;
		s_nxt.load = 1'b0;
		s_nxt.logw = 1'b0;
		s_nxt.pwm_off = 1'b0;
		s_nxt.fclr = 1'b0;
		s_nxt.pins = 1'b0;
		s_nxt.start = 1'b0;
		s_nxt.comm_memory_logic_fault = 1'b0;
		s_nxt.rval = 1'b0;
		s_nxt.hot = (die_temp_c > TEMP_HOT_C);
		cool = (die_temp_c < TEMP_UNLOCK_C);
		// Lockout with hysteresis
		if (die_temp_c > TEMP_LOCK_C)
			s_nxt.lock = 1'b1;
		else if (cool)
			s_nxt.lock = 1'b0;
		// Deferred record-save fires once cool or unlocked, and memory not busy
		if (s_r.pend && (cool || !s_r.lock) && !mem_busy)
		begin
			s_nxt.pend = 1'b0;
			s_nxt.logw = 1'b1;
		end
		act = cmd_valid && s_r.st == NV_IDLE;
		if (act)
		begin
			case (cmd_code)
				CMD_STORE_ALL:
				begin
					if (!cmd_write || cmd_has_data)
						s_nxt.comm_memory_logic_fault = 1'b1;
					else if (!s_r.lock)
						s_nxt.store = 1'b1;
				end
				CMD_RESTORE_ALL:
				begin
					if (!cmd_write || cmd_has_data)
						s_nxt.comm_memory_logic_fault = 1'b1;
					else
					begin
						s_nxt.st = NV_PWM_OFF;
						s_nxt.pwm_off = 1'b1;
					end
				end
				CMD_VERIFY:
				begin
					if (!cmd_write || cmd_has_data)
						s_nxt.comm_memory_logic_fault = 1'b1;
					else if (!s_r.lock && mem_differs)
						s_nxt.comm_memory_logic_fault = 1'b1;
				end
				CMD_REC_SAVE:
				begin
					if (!cmd_write || cmd_has_data)
						s_nxt.comm_memory_logic_fault = 1'b1;
					else if (!log_enable)
						s_nxt.comm_memory_logic_fault = 1'b1;
					else if (s_r.lock || mem_busy)
						s_nxt.pend = 1'b1;
					else
						s_nxt.logw = 1'b1;
				end
				CMD_SCRATCH_PAGED, CMD_SCRATCH_GLOBAL:
				begin
					if (cmd_write)
					begin
						if (!s_r.lock)
						begin
							if (cmd_code == CMD_SCRATCH_GLOBAL)
								s_nxt.scr_g = cmd_wdata;
							else if (cmd_page)
								s_nxt.scr_p1 = cmd_wdata;
							else
								s_nxt.scr_p0 = cmd_wdata;
						end
					end
					else if (!s_r.lock)
					begin
						s_nxt.rval = 1'b1;
						s_nxt.rlen = 8'd2;
						if (cmd_code == CMD_SCRATCH_GLOBAL)
							s_nxt.rdat = s_r.scr_g;
						else
							s_nxt.rdat = cmd_page ? s_r.scr_p1 : s_r.scr_p0;
					end
				end
				CMD_MAKER_STR, CMD_MODEL_STR, CMD_SERIAL_STR:
				begin
					if (cmd_write)
						s_nxt.comm_memory_logic_fault = 1'b1;
					else
					begin
						s_nxt.rval = 1'b1;
						s_nxt.rlen = {4'h0, STR_LEN};
						s_nxt.rdat = {8'h00, str_char(cmd_code, str_idx)};
					end
				end
				CMD_PART_ID:
				begin
					if (cmd_write)
						s_nxt.comm_memory_logic_fault = 1'b1;
					else
					begin
						s_nxt.rval = 1'b1;
						s_nxt.rlen = 8'd2;
						s_nxt.rdat = PART_ID_VAL;
					end
				end
				default: ;
			endcase
		end
		// Restore sequence, one step per cycle
		case (s_r.st)
			NV_IDLE: ;
			NV_PWM_OFF:
			begin
				s_nxt.st = NV_LOAD;
				s_nxt.load = 1'b1;
			end
			NV_LOAD:
			begin
				s_nxt.st = NV_CLEAR;
				s_nxt.fclr = 1'b1;
			end
			NV_CLEAR:
			begin
				s_nxt.st = NV_PINS;
				s_nxt.pins = 1'b1;
			end
			NV_PINS:
			begin
				s_nxt.st = NV_START;
				s_nxt.start = 1'b1;
			end
			NV_START: s_nxt.st = NV_IDLE;
			default: s_nxt.st = NV_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			s_r <= '0;
			s_r.st <= NV_IDLE;
			s_r.scr_p0 <= SCRATCH_RST;
			s_r.scr_p1 <= SCRATCH_RST;
			s_r.scr_g <= SCRATCH_RST;
		end
		else
			s_r <= s_nxt;
	end

	assign rd_data = s_r.rdat;
	assign rd_len = s_r.rlen;
	assign rd_valid = s_r.rval;
	assign nv_store = s_r.store;
	assign nv_load = s_r.load;
	assign nv_log_write = s_r.logw;
	assign pwm_force_off = s_r.pwm_off;
	assign faults_clear = s_r.fclr;
	assign pins_sample = s_r.pins;
	assign soft_start = s_r.start;
	assign cml_fault = s_r.comm_memory_logic_fault;
	assign hot_flag = s_r.hot;
	assign lockout = s_r.lock;
	assign log_pending = s_r.pend;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_lock_blocks_store: assert property (@(posedge clk) disable iff (!rst_int_n)
		(cmd_valid && cmd_code == CMD_STORE_ALL && s_r.lock) |=> !nv_store)
		else $error("store ran during lockout");
	chk_lock_sets: assert property (@(posedge clk) disable iff (!rst_int_n)
		(die_temp_c > TEMP_LOCK_C) |=> lockout)
		else $error("lockout not set when hot");
	chk_restore_order: assert property (@(posedge clk) disable iff (!rst_int_n)
		pwm_force_off |=> nv_load ##1 faults_clear ##1 pins_sample ##1 soft_start)
		else $error("restore steps out of order");
	chk_restore_in_lock: assert property (@(posedge clk) disable iff (!rst_int_n)
		(cmd_valid && cmd_code == CMD_RESTORE_ALL && cmd_write && !cmd_has_data
		&& s_r.st == NV_IDLE) |=> pwm_force_off)
		else $error("restore not started at once");
	chk_pend_hold: assert property (@(posedge clk) disable iff (!rst_int_n)
		(log_pending && lockout && !(die_temp_c < TEMP_UNLOCK_C)) |=> !nv_log_write)
		else $error("record-save not deferred");
	chk_log_disabled: assert property (@(posedge clk) disable iff (!rst_int_n)
		(cmd_valid && s_r.st == NV_IDLE && cmd_code == CMD_REC_SAVE && cmd_write
		&& !cmd_has_data && !log_enable) |=> cml_fault)
		else $error("missing fault on disabled logging");
	chk_verify_fault: assert property (@(posedge clk) disable iff (!rst_int_n)
		(cmd_valid && s_r.st == NV_IDLE && cmd_code == CMD_VERIFY && cmd_write
		&& !cmd_has_data && !s_r.lock && mem_differs) |=> cml_fault)
		else $error("verify mismatch not flagged");
	chk_scratch_lock: assert property (@(posedge clk) disable iff (!rst_int_n)
		s_r.lock |=> $stable(s_r.scr_g))
		else $error("scratch changed in lockout");
	chk_part_id: assert property (@(posedge clk) disable iff (!rst_int_n)
		(cmd_valid && s_r.st == NV_IDLE && cmd_code == CMD_PART_ID && !cmd_write)
		|=> rd_valid && rd_data == PART_ID_VAL && rd_len == 8'd2)
		else $error("part identity answer wrong");
endmodule
`default_nettype wire

/* include/nvua_pkg.sv */
// Constants and types for the nonvolatile user access command block
// Functional notes
// - Above 130C refuse commands except restore, record-save; code still answers string and part-ID reads
// - Lockout: restore runs, record-save waits below 125C
// - Store 0x15, restore 0x16, verify 0xF0, unpaged
// - Record-save is unpaged send-byte code 0xEA
// - Store copies all operating memory to nonvolatile
// - Restore: PWM off, reload, clear, pins, start
// - Verify mismatch raises comm/memory/logic fault
// - Record-save writes log like a fault
// - Logging disabled: record-save raises fault
// - Action commands are write-only, no data
// - Three scratch words: 0xB3 paged (two), 0xB4 (one), zero
// - 0x99 returns maker string, read-only block
// - 0x9A returns model string, read-only block
// - 0x9E returns serial, at most fourteen chars
// - 0xE7 returns 16-bit part identity word
package nvua_pkg;
	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_STORE_ALL = 8'h15;
	localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
	localparam logic [7:0] CMD_VERIFY = 8'hf0;
	localparam logic [7:0] CMD_REC_SAVE = 8'hea;
	localparam logic [7:0] CMD_SCRATCH_PAGED = 8'hb3;
	localparam logic [7:0] CMD_SCRATCH_GLOBAL = 8'hb4;
	localparam logic [7:0] CMD_MAKER_STR = 8'h99;
	localparam logic [7:0] CMD_MODEL_STR = 8'h9a;
	localparam logic [7:0] CMD_SERIAL_STR = 8'h9e;
	localparam logic [7:0] CMD_PART_ID = 8'he7;
	// ------------------------------------------------------------
	// Reset values, limits, fields
	// ------------------------------------------------------------
	localparam logic [15:0] SCRATCH_RST = 16'h0000;
	localparam logic [15:0] PART_ID_VAL = 16'h5a50; // Arbitrary value
	localparam logic [7:0] TEMP_LOCK_C = 8'd130;
	localparam logic [7:0] TEMP_UNLOCK_C = 8'd125;
	localparam logic [7:0] TEMP_HOT_C = 8'd85;
	localparam int STR_MAX = 14;
	localparam logic [3:0] STR_LEN = 4'd4;
	localparam logic [7:0] MAKER_CH [4] = '{8'h41, 8'h42, 8'h43, 8'h44}; // Arbitrary
	localparam logic [7:0] MODEL_CH [4] = '{8'h4d, 8'h30, 8'h30, 8'h31}; // Arbitrary
	localparam logic [7:0] SERIAL_CH [4] = '{8'h53, 8'h30, 8'h30, 8'h30}; // Arbitrary
	localparam int VSB_HOT_BIT = 6;
	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		NV_IDLE = 3'b000,
		NV_PWM_OFF = 3'b001,
		NV_LOAD = 3'b011,
		NV_CLEAR = 3'b010,
		NV_PINS = 3'b110,
		NV_START = 3'b111
	} nvua_state_t;
endpackage

/* testbench/nvua_host.sv */
// Host model that issues commands to the nonvolatile access block
`timescale 1ns/100ps
`default_nettype none
module nvua_host (
	// Clock and status
	input wire logic clk,
	input wire logic hot_flag,
	// Command to block
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic cmd_write,
	output logic cmd_has_data,
	output logic [15:0] cmd_wdata,
	output logic cmd_page,
	output logic [4:0] str_idx
);
	import nvua_pkg::*;
	bit rude = 1'b0;
	initial
		{cmd_valid, cmd_code, cmd_write, cmd_has_data, cmd_wdata, cmd_page, str_idx} = '0;
	task automatic send(input logic [7:0] code, input logic wr, input logic hd,
		input logic [15:0] wd, input logic pg, input logic [4:0] ix);
		logic nvw;
		nvw = wr && (code == CMD_STORE_ALL || code == CMD_SCRATCH_PAGED
			|| code == CMD_SCRATCH_GLOBAL);
		// Hot die: no nonvolatile write unless the scenario insists
		if (nvw && hot_flag && !rude)
			return;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_write <= wr;
		cmd_has_data <= hd;
		cmd_wdata <= wd;
		cmd_page <= pg;
		str_idx <= ix;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_code <= ~code;
		cmd_wdata <= ~wd;
	endtask
endmodule
`default_nettype wire

/* testbench/test_pmbus_eeprom_user_access.sv */
// Self-checking bench for the nonvolatile access block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_pmbus_eeprom_user_access;
	import nvua_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] die_temp_c = 8'd25;
	logic log_enable = 1'b1;
	logic mem_differs = 1'b0;
	logic mem_busy = 1'b0;
	logic cmd_valid, cmd_write, cmd_has_data, cmd_page, rd_valid;
	logic [7:0] cmd_code, rd_len;
	logic [15:0] cmd_wdata, rd_data;
	logic [4:0] str_idx;
	logic nv_store, nv_load, nv_log_write, pwm_force_off, faults_clear, pins_sample;
	logic soft_start, cml_fault, hot_flag, lockout, log_pending;
	logic [8:0] pul;
	int cnt [9];
	int stamp [9];
	int cyc = 0;
	int n_errors = 0;
	int compares = 0;
	nvua_core nvua_core_i (.clk, .rst_n, .cmd_valid, .cmd_code, .cmd_write, .cmd_has_data,
		.cmd_wdata, .cmd_page, .str_idx, .die_temp_c, .log_enable, .mem_differs, .mem_busy,
		.rd_data, .rd_len, .rd_valid, .nv_store, .nv_load, .nv_log_write, .pwm_force_off,
		.faults_clear, .pins_sample, .soft_start, .cml_fault, .hot_flag, .lockout,
		.log_pending);
	nvua_host nvua_host_i (.clk, .hot_flag, .cmd_valid, .cmd_code, .cmd_write,
		.cmd_has_data, .cmd_wdata, .cmd_page, .str_idx);
	// ----
	// Pulse counting and timeout
	// ----
	assign pul = {rd_valid, cml_fault, soft_start, pins_sample, faults_clear, pwm_force_off,
		nv_log_write, nv_load, nv_store};
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		for (int i = 0; i < 9; i++)
			if (pul[i] === 1'b1)
			begin
				cnt[i]++;
				stamp[i] = cyc;
			end
		if (cyc == 3000)
		begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----
	// Shared steps
	// ----
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic op(input logic [7:0] code, input logic wr, input logic hd,
		input logic [15:0] wd, input logic pg, input logic [4:0] ix, input int k, input int d);
		int c0;
		c0 = cnt[k];
		nvua_host_i.send(code, wr, hd, wd, pg, ix);
		wait_n(2);
		`CHK("pulse count", c0 + d, cnt[k])
	endtask
	task automatic snd(input logic [7:0] code, input int k, input int d);
		op(code, 1'b1, 1'b0, 16'h0, 1'b0, 5'h0, k, d);
	endtask
	task automatic rd(input logic [7:0] code, input logic pg, input logic [15:0] e);
		op(code, 1'b0, 1'b0, 16'h0, pg, 5'h0, 8, 1);
		`CHK("read data", e, rd_data)
	endtask
	task automatic wr(input logic [7:0] code, input logic pg, input logic [15:0] v);
		op(code, 1'b1, 1'b1, v, pg, 5'h0, 7, 0);
	endtask
	task automatic temp(input logic [7:0] v);
		@(posedge clk) die_temp_c <= v;
		wait_n(3);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_ident();
		logic [7:0] codes [3];
		logic [7:0] ch;
		codes = '{CMD_MAKER_STR, CMD_MODEL_STR, CMD_SERIAL_STR};
		rd(CMD_SCRATCH_GLOBAL, 1'b0, SCRATCH_RST);
		rd(CMD_SCRATCH_PAGED, 1'b1, SCRATCH_RST);
		rd(CMD_PART_ID, 1'b0, PART_ID_VAL);
		`CHK("word length", 8'd2, rd_len)
		for (int s = 0; s < 3; s++)
			for (int i = 0; i <= 4; i++)
			begin
				op(codes[s], 1'b0, 1'b0, 16'h0, 1'b0, 5'(i), 8, 1);
				ch = 8'(STR_LEN);
				if (i > 0)
					ch = s == 0 ? MAKER_CH[i-1] : s == 1 ? MODEL_CH[i-1] : SERIAL_CH[i-1];
				`CHK("string char", ch, rd_data[7:0])
				`CHK("string length", 8'(STR_LEN), rd_len)
			end
		`CHK("serial fits", 1'b1, rd_len <= 8'(STR_MAX))
	endtask
	task automatic t_scratch();
		wr(CMD_SCRATCH_GLOBAL, 1'b0, 16'h1234);
		wr(CMD_SCRATCH_PAGED, 1'b1, 16'hbeef);
		wr(CMD_SCRATCH_PAGED, 1'b0, 16'h5a5a);
		rd(CMD_SCRATCH_PAGED, 1'b1, 16'hbeef);
		rd(CMD_SCRATCH_PAGED, 1'b0, 16'h5a5a);
		rd(CMD_SCRATCH_GLOBAL, 1'b1, 16'h1234);
	endtask
	task automatic t_actions();
		int seq [5];
		seq = '{3, 1, 4, 5, 6};
		snd(CMD_STORE_ALL, 0, 1);
		snd(CMD_VERIFY, 7, 0);
		@(posedge clk) mem_differs <= 1'b1;
		snd(CMD_VERIFY, 7, 1);
		snd(CMD_REC_SAVE, 2, 1);
		@(posedge clk) log_enable <= 1'b0;
		snd(CMD_REC_SAVE, 7, 1);
		@(posedge clk) log_enable <= 1'b1;
		op(CMD_STORE_ALL, 1'b0, 1'b0, 16'h0, 1'b0, 5'h0, 7, 1);
		op(CMD_RESTORE_ALL, 1'b1, 1'b1, 16'h1, 1'b0, 5'h0, 7, 1);
		op(CMD_PART_ID, 1'b1, 1'b1, 16'h1, 1'b0, 5'h0, 7, 1);
		snd(CMD_RESTORE_ALL, 3, 1);
		wait_n(5);
		for (int i = 1; i < 5; i++)
			`CHK("restore step", stamp[seq[i-1]] + 1, stamp[seq[i]])
	endtask
	task automatic t_lockout();
		int c0;
		temp(8'd86);
		`CHK("hot flag", 1'b1, hot_flag)
		temp(8'd130);
		`CHK("lockout", 1'b0, lockout)
		temp(8'd131);
		`CHK("lockout", 1'b1, lockout)
		nvua_host_i.rude = 1'b1;
		snd(CMD_STORE_ALL, 0, 0);
		snd(CMD_VERIFY, 7, 0);
		wr(CMD_SCRATCH_GLOBAL, 1'b0, 16'hdead);
		op(CMD_SCRATCH_GLOBAL, 1'b0, 1'b0, 16'h0, 1'b0, 5'h0, 8, 0);
		snd(CMD_RESTORE_ALL, 1, 1);
		wait_n(5);
		c0 = cnt[2];
		snd(CMD_REC_SAVE, 2, 0);
		`CHK("log pending", 1'b1, log_pending)
		temp(8'd125);
		`CHK("lockout", 1'b1, lockout)
		`CHK("deferred save", c0, cnt[2])
		@(posedge clk) mem_busy <= 1'b1;
		temp(8'd124);
		`CHK("lockout", 1'b0, lockout)
		`CHK("deferred save", c0, cnt[2])
		@(posedge clk) mem_busy <= 1'b0;
		wait_n(4);
		`CHK("deferred save", c0 + 1, cnt[2])
		`CHK("log pending", 1'b0, log_pending)
		nvua_host_i.rude = 1'b0;
		@(posedge clk) mem_differs <= 1'b0;
		temp(8'd25);
		rd(CMD_SCRATCH_GLOBAL, 1'b0, 16'h1234);
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_ident();
		t_scratch();
		t_actions();
		t_lockout();
		report_and_stop();
	end
endmodule
`default_nettype wire
